// *** rtl/fbrsp_params.svh ***
`ifndef FBRSP_PARAMS_SVH
`define FBRSP_PARAMS_SVH

// Clock rate in MHz; every time-based cycle count below is derived from it.
`define FBRSP_CLK_MHZ 200

// Least-time conversion from ns to cycles, rounded up, never below one.
`define FBRSP_NS2CYC(ns) ((((ns) * `FBRSP_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
    (((ns) * `FBRSP_CLK_MHZ + 999) / 1000))

// Documented times.
`define FBRSP_T_RST_BUSY_US 20
`define FBRSP_T_RST_READ_NS 500
`define FBRSP_T_RST_GAP_NS 50
`define FBRSP_T_PROT_US 100
`define FBRSP_T_UNPROT_MS 10
`define FBRSP_T_GLITCH_NS 5

// Controller timings with no documented figure.
`define FBRSP_T_RST_PULSE_NS 500
`define FBRSP_T_SETUP_NS 100
`define FBRSP_T_ACCESS_NS 120

// Derived cycle counts.
`define FBRSP_RST_BUSY_CYC `FBRSP_NS2CYC(`FBRSP_T_RST_BUSY_US * 1000)
`define FBRSP_RST_READ_CYC `FBRSP_NS2CYC(`FBRSP_T_RST_READ_NS)
`define FBRSP_RST_GAP_CYC `FBRSP_NS2CYC(`FBRSP_T_RST_GAP_NS)
`define FBRSP_PROT_CYC `FBRSP_NS2CYC(`FBRSP_T_PROT_US * 1000)
`define FBRSP_UNPROT_CYC `FBRSP_NS2CYC(`FBRSP_T_UNPROT_MS * 1000000)
`define FBRSP_GLITCH_CYC `FBRSP_NS2CYC(`FBRSP_T_GLITCH_NS)
`define FBRSP_RST_PULSE_CYC `FBRSP_NS2CYC(`FBRSP_T_RST_PULSE_NS)
`define FBRSP_SETUP_CYC `FBRSP_NS2CYC(`FBRSP_T_SETUP_NS)
`define FBRSP_ACCESS_CYC `FBRSP_NS2CYC(`FBRSP_T_ACCESS_NS)

// Synchroniser depth added to every sampled read.
`define FBRSP_SYNC_LAT 4

// Address field positions on the flash pins.
`define FBRSP_A0_POS 0
`define FBRSP_A1_POS 1
`define FBRSP_A6_POS 6
`define FBRSP_SECT_LSB 13
`define FBRSP_SECT_MSB 19

// Operation codes on the command port.
`define FBRSP_OP_RESET 3'h0
`define FBRSP_OP_PDOWN 3'h1
`define FBRSP_OP_PROT 3'h2
`define FBRSP_OP_UNPROT 3'h3
`define FBRSP_OP_VFY_PROT 3'h4
`define FBRSP_OP_VFY_UNPROT 3'h5

// Number of sectors that must be protected before an unprotect.
`define FBRSP_NUM_SECTORS 19

`endif

// *** rtl/fbrsp_pkg.sv ***
`default_nettype none
package fbrsp_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RST_LOW,
        ST_RST_WAIT,
        ST_RST_GAP,
        ST_PDOWN,
        ST_SETUP,
        ST_WE_LOW,
        ST_WE_HOLD,
        ST_RD,
        ST_DONE
    } fbrsp_state_t;

endpackage : fbrsp_pkg

`default_nettype wire

// *** rtl/fbrsp_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// Three-stage synchroniser; the output follows only once stages two and three agree.
module fbrsp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_ff <= INIT;
            s2_ff <= INIT;
            s3_ff <= INIT;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout <= INIT;
        end else if (s2_ff == s3_ff) begin
            dout <= s3_ff;
        end
    end

endmodule : fbrsp_sync

`default_nettype wire

// *** rtl/fbrsp_host.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "fbrsp_params.svh"

// Contract
// - Reset in busy: watch ready or 20us.
// - Wait 50ns after reset before reading.
// - Treat interrupted locations as corrupt afterwards.
// - Protect entry pin levels, sector selected.
// - Protect write pulse low 100us.
// - Protect every sector before unprotecting; the code counts NUM_SECTORS protect commands, not distinct sectors.
// - Unprotect pin levels, 10ms write pulse.
module fbrsp_host #(
    parameter int PROT_PULSE_CYC = `FBRSP_PROT_CYC,
    parameter int UNPROT_PULSE_CYC = `FBRSP_UNPROT_CYC,
    parameter int NUM_SECTORS = `FBRSP_NUM_SECTORS
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // User command port
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_OP,
    input wire logic [6:0] CMD_SECTOR,
    output logic CMD_READY,
    input wire logic TEMP_UNPROT,
    // User result port
    output logic DONE,
    output logic REFUSED,
    output logic CORRUPT,
    output logic RESULT_PROT,
    output logic [7:0] RESULT_DATA,
    output logic DEV_READY,
    output logic POWER_DOWN,
    // Flash pins
    output logic [19:0] F_ADDR,
    input wire logic [7:0] F_DQ_I,
    output logic [7:0] F_DQ_O,
    output logic F_DQ_OE,
    output logic F_CE_N,
    output logic F_OE_N,
    output logic F_WE_N,
    output logic F_RESET_N,
    input wire logic F_READY_BUSY_N,
    // High-voltage qualifiers
    output logic F_ID_HV,
    output logic F_OE_HV,
    output logic F_RESET_HV
);

    localparam int TMR_W = 24;

    // Pulses must outlast the glitch filter and fit the timer.
    if (PROT_PULSE_CYC <= `FBRSP_GLITCH_CYC || PROT_PULSE_CYC >= (1 << TMR_W)) begin : g_chk_p
        $error("fbrsp_host: PROT_PULSE_CYC out of range");
    end
    if (UNPROT_PULSE_CYC <= `FBRSP_GLITCH_CYC || UNPROT_PULSE_CYC >= (1 << TMR_W)) begin : g_chk_u
        $error("fbrsp_host: UNPROT_PULSE_CYC out of range");
    end
    if (NUM_SECTORS < 1 || NUM_SECTORS > 255) begin : g_chk_n
        $error("fbrsp_host: NUM_SECTORS out of range");
    end

    function automatic logic [TMR_W-1:0] cyc(input int n);
        cyc = TMR_W'(n - 1);
    endfunction : cyc
    function automatic logic is_write_op(input logic [2:0] op);
        is_write_op = (op == `FBRSP_OP_PROT) || (op == `FBRSP_OP_UNPROT);
    endfunction : is_write_op

    fbrsp_pkg::fbrsp_state_t state_ff;
    fbrsp_pkg::fbrsp_state_t nxt_state;
    logic [TMR_W-1:0] tmr_ff;
    logic [TMR_W-1:0] nxt_tmr;
    logic [2:0] op_ff;
    logic [6:0] sect_ff;
    logic was_busy_ff;
    logic [7:0] prot_cnt_ff;
    logic ready_s;
    logic [7:0] dq_s;
    logic accept;
    logic refuse;
    logic tmr_zero;
    logic pin_act;
    logic [19:0] pin_addr;

    // The ready line is wired-OR low across devices, so it is only ever sampled here.
    fbrsp_sync #(.WIDTH(1), .INIT(1'b1)) u_sync_rdy (
        .clk(CLK),
        .rst(RST),
        .din(F_READY_BUSY_N),
        .dout(ready_s)
    );

    fbrsp_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_dq (
        .clk(CLK),
        .rst(RST),
        .din(F_DQ_I),
        .dout(dq_s)
    );

    assign tmr_zero = (tmr_ff == '0);
    assign CMD_READY = (state_ff == fbrsp_pkg::ST_IDLE) || (state_ff == fbrsp_pkg::ST_PDOWN);
    assign accept = CMD_VALID && CMD_READY;
    assign pin_act = (state_ff == fbrsp_pkg::ST_SETUP) || (state_ff == fbrsp_pkg::ST_WE_LOW) ||
                     (state_ff == fbrsp_pkg::ST_WE_HOLD) || (state_ff == fbrsp_pkg::ST_RD);
    assign pin_addr = (20'(sect_ff) << `FBRSP_SECT_LSB) | (20'h00001 << `FBRSP_A1_POS) |
                      (20'((op_ff == `FBRSP_OP_UNPROT) || (op_ff == `FBRSP_OP_VFY_UNPROT))
                       << `FBRSP_A6_POS);

    // A busy device takes no protect work; unprotect also needs NUM_SECTORS completed protect commands first.
    always_comb begin
        refuse = 1'b0;
        if (state_ff == fbrsp_pkg::ST_PDOWN) begin
            refuse = (CMD_OP != `FBRSP_OP_RESET);
        end else if (CMD_OP == `FBRSP_OP_UNPROT) begin
            refuse = !ready_s || (prot_cnt_ff < 8'(NUM_SECTORS));
        end else if (CMD_OP != `FBRSP_OP_RESET && CMD_OP != `FBRSP_OP_PDOWN) begin
            refuse = !ready_s || (CMD_OP > `FBRSP_OP_VFY_UNPROT);
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_tmr = tmr_zero ? '0 : tmr_ff - 1'b1;
        case (state_ff)
            fbrsp_pkg::ST_IDLE, fbrsp_pkg::ST_PDOWN: begin
                if (accept && !refuse) begin
                    if (CMD_OP == `FBRSP_OP_RESET || CMD_OP == `FBRSP_OP_PDOWN) begin
                        nxt_state = fbrsp_pkg::ST_RST_LOW;
                        nxt_tmr = cyc(`FBRSP_RST_PULSE_CYC);
                    end else begin
                        nxt_state = fbrsp_pkg::ST_SETUP;
                        nxt_tmr = cyc(`FBRSP_SETUP_CYC);
                    end
                end
            end
            fbrsp_pkg::ST_RST_LOW: begin
                if (tmr_zero) begin
                    if (op_ff == `FBRSP_OP_PDOWN) begin
                        nxt_state = fbrsp_pkg::ST_PDOWN;
                    end else begin
                        nxt_state = fbrsp_pkg::ST_RST_WAIT;
                        nxt_tmr = was_busy_ff ? cyc(`FBRSP_RST_BUSY_CYC)
                                              : cyc(`FBRSP_RST_READ_CYC);
                    end
                end
            end
            fbrsp_pkg::ST_RST_WAIT: begin
                // Busy-reset ends early once the synced ready line is high, but only after more than 8 cycles in this state.
                if (tmr_zero || (was_busy_ff && ready_s &&
                                 tmr_ff < cyc(`FBRSP_RST_BUSY_CYC) - 8)) begin
                    nxt_state = fbrsp_pkg::ST_RST_GAP;
                    nxt_tmr = cyc(`FBRSP_RST_GAP_CYC);
                end
            end
            fbrsp_pkg::ST_RST_GAP: begin
                if (tmr_zero) begin
                    nxt_state = fbrsp_pkg::ST_DONE;
                end
            end
            fbrsp_pkg::ST_SETUP: begin
                if (tmr_zero) begin
                    if (is_write_op(op_ff)) begin
                        nxt_state = fbrsp_pkg::ST_WE_LOW;
                        nxt_tmr = (op_ff == `FBRSP_OP_PROT) ? cyc(PROT_PULSE_CYC)
                                                           : cyc(UNPROT_PULSE_CYC);
                    end else begin
                        nxt_state = fbrsp_pkg::ST_RD;
                        nxt_tmr = cyc(`FBRSP_ACCESS_CYC + `FBRSP_SYNC_LAT);
                    end
                end
            end
            fbrsp_pkg::ST_WE_LOW: begin
                if (tmr_zero) begin
                    nxt_state = fbrsp_pkg::ST_WE_HOLD;
                    nxt_tmr = cyc(`FBRSP_SETUP_CYC);
                end
            end
            fbrsp_pkg::ST_WE_HOLD, fbrsp_pkg::ST_RD: begin
                if (tmr_zero) begin
                    nxt_state = fbrsp_pkg::ST_DONE;
                end
            end
            fbrsp_pkg::ST_DONE: begin
                nxt_state = fbrsp_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = fbrsp_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_ff <= fbrsp_pkg::ST_IDLE;
            tmr_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            tmr_ff <= nxt_tmr;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            op_ff <= `FBRSP_OP_RESET;
            sect_ff <= 7'h00;
            was_busy_ff <= 1'b0;
        end else if (accept && !refuse) begin
            op_ff <= CMD_OP;
            sect_ff <= CMD_SECTOR;
            was_busy_ff <= !ready_s;
        end
    end

    // Sectors start unprotected; the count is a proxy, it does not track distinct sectors.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prot_cnt_ff <= 8'h00;
        end else if (state_ff == fbrsp_pkg::ST_DONE) begin
            if (op_ff == `FBRSP_OP_PROT && prot_cnt_ff != 8'hff) begin
                prot_cnt_ff <= prot_cnt_ff + 8'h01;
            end else if (op_ff == `FBRSP_OP_UNPROT) begin
                prot_cnt_ff <= 8'h00;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            DONE <= 1'b0;
            REFUSED <= 1'b0;
            CORRUPT <= 1'b0;
            RESULT_PROT <= 1'b0;
            RESULT_DATA <= 8'h00;
            DEV_READY <= 1'b0;
            POWER_DOWN <= 1'b0;
        end else begin
            DONE <= (state_ff == fbrsp_pkg::ST_DONE) || (nxt_state == fbrsp_pkg::ST_PDOWN &&
                                                        state_ff == fbrsp_pkg::ST_RST_LOW);
            REFUSED <= accept && refuse;
            CORRUPT <= (state_ff == fbrsp_pkg::ST_RST_GAP) && tmr_zero && was_busy_ff;
            DEV_READY <= ready_s;
            POWER_DOWN <= (nxt_state == fbrsp_pkg::ST_PDOWN);
            if (state_ff == fbrsp_pkg::ST_RD && tmr_zero) begin
                RESULT_DATA <= dq_s;
                RESULT_PROT <= (dq_s == 8'h01);
            end
        end
    end

    // Pins are registered and each is written once per edge, so no strobe glitches in zero time.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            F_ADDR <= 20'h00000;
            F_DQ_O <= 8'h00;
            F_DQ_OE <= 1'b0;
            F_CE_N <= 1'b1;
            F_OE_N <= 1'b1;
            F_WE_N <= 1'b1;
            F_RESET_N <= 1'b1;
            F_ID_HV <= 1'b0;
            F_OE_HV <= 1'b0;
            F_RESET_HV <= 1'b0;
        end else begin
            F_ADDR <= pin_act ? pin_addr : 20'h00000;
            F_DQ_O <= 8'h00;
            F_DQ_OE <= pin_act && is_write_op(op_ff);
            F_CE_N <= !pin_act;
            F_OE_N <= (state_ff != fbrsp_pkg::ST_RD);
            F_WE_N <= (state_ff != fbrsp_pkg::ST_WE_LOW);
            F_RESET_N <= !(state_ff == fbrsp_pkg::ST_RST_LOW ||
                           state_ff == fbrsp_pkg::ST_PDOWN);
            F_ID_HV <= pin_act;
            F_OE_HV <= pin_act && is_write_op(op_ff);
            F_RESET_HV <= TEMP_UNPROT && (state_ff == fbrsp_pkg::ST_IDLE);
        end
    end

endmodule : fbrsp_host

`default_nettype wire

// *** verif/fbrsp_host_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module fbrsp_host_monitor #(
    parameter int PROT_PULSE_CYC = 20,
    parameter int UNPROT_PULSE_CYC = 30
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // User side
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_OP,
    input wire logic CMD_READY,
    input wire logic TEMP_UNPROT,
    input wire logic REFUSED,
    input wire logic RESULT_PROT,
    input wire logic [7:0] RESULT_DATA,
    input wire logic DEV_READY,
    input wire logic POWER_DOWN,
    // Flash side
    input wire logic [19:0] F_ADDR,
    input wire logic F_DQ_OE,
    input wire logic F_CE_N,
    input wire logic F_OE_N,
    input wire logic F_WE_N,
    input wire logic F_RESET_N,
    input wire logic F_ID_HV,
    input wire logic F_OE_HV,
    input wire logic F_RESET_HV
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    int we_low_cnt;
    int up_cnt;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) we_low_cnt <= 0;
        else if (!F_WE_N) we_low_cnt <= we_low_cnt + 1;
        else we_low_cnt <= 0;
    end
    // Counts cycles since the reset pin was last released, saturating.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) up_cnt <= 255;
        else if (!F_RESET_N) up_cnt <= 0;
        else if (up_cnt < 255) up_cnt <= up_cnt + 1;
    end
    sequence s_rst_low;
        !F_RESET_N && F_CE_N && F_WE_N;
    endsequence
    AST_RST_HOLD: assert property ($fell(F_RESET_N) |-> s_rst_low [*8])
        else $error("reset pulse not held with strobes idle");
    // DEV_READY trails the ready level the design decides on by one cycle, so it is read then.
    AST_BUSY_REFUSE: assert property ((CMD_VALID && CMD_READY && !POWER_DOWN
        && CMD_OP inside {[3'h2:3'h5]}) ##1 !DEV_READY |-> REFUSED)
        else $error("busy command not refused");
    AST_PROT_LEN: assert property ($rose(F_WE_N) && !F_ADDR[6] |-> we_low_cnt == PROT_PULSE_CYC)
        else $error("protect pulse length wrong");
    AST_UNPROT_LEN: assert property ($rose(F_WE_N) && F_ADDR[6] |-> we_low_cnt == UNPROT_PULSE_CYC)
        else $error("unprotect pulse length wrong");
    AST_PROT_PINS: assert property (!F_WE_N |-> !F_CE_N && F_ID_HV && F_OE_HV && !F_ADDR[0]
        && F_ADDR[1]) else $error("protect pin levels wrong");
    AST_WE_STABLE: assert property (!F_WE_N && !$past(F_WE_N) |-> $stable(F_ADDR) && F_DQ_OE)
        else $error("address moved in write pulse");
    AST_VFY_PINS: assert property (!F_OE_N |-> F_WE_N && !F_CE_N && F_ID_HV && !F_OE_HV
        && !F_ADDR[0] && F_ADDR[1] && !F_DQ_OE) else $error("verify pin levels wrong");
    AST_READ_GAP: assert property (!F_OE_N |-> up_cnt >= 10)
        else $error("read too soon after reset");
    AST_PDOWN: assert property (POWER_DOWN |-> !F_RESET_N)
        else $error("power-down without reset low");
    AST_RESULT: assert property (RESULT_PROT == (RESULT_DATA == 8'h01))
        else $error("result flag disagrees with byte");
    AST_TEMP: assert property ((TEMP_UNPROT && CMD_READY && !POWER_DOWN) [*2] |-> F_RESET_HV)
        else $error("temporary unprotect not driven");
endmodule : fbrsp_host_monitor
bind fbrsp_host fbrsp_host_monitor #(.PROT_PULSE_CYC(PROT_PULSE_CYC),
    .UNPROT_PULSE_CYC(UNPROT_PULSE_CYC)) u_mon (.CLK(CLK), .RST(RST), .CMD_VALID(CMD_VALID),
    .CMD_OP(CMD_OP), .CMD_READY(CMD_READY), .TEMP_UNPROT(TEMP_UNPROT), .REFUSED(REFUSED),
    .RESULT_PROT(RESULT_PROT), .RESULT_DATA(RESULT_DATA), .DEV_READY(DEV_READY),
    .POWER_DOWN(POWER_DOWN), .F_ADDR(F_ADDR), .F_DQ_OE(F_DQ_OE), .F_CE_N(F_CE_N),
    .F_OE_N(F_OE_N), .F_WE_N(F_WE_N), .F_RESET_N(F_RESET_N), .F_ID_HV(F_ID_HV),
    .F_OE_HV(F_OE_HV), .F_RESET_HV(F_RESET_HV));
`default_nettype wire

// *** verif/fbrsp_flash_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module fbrsp_flash_model (
    // Flash pins
    input wire logic [19:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    input wire logic id_hv,
    input wire logic oe_hv,
    input wire logic [7:0] host_dq,
    input wire logic host_oe,
    output logic [7:0] dq,
    output logic rb_low,
    // Test control
    input wire logic start_op
);
    logic prot [0:127];
    logic busy = 1'b0;
    logic rst_busy = 1'b0;
    logic dev_oe;
    logic [7:0] rd;
    logic [7:0] last = 8'h00;
    realtime t_fall = 0;
    initial foreach (prot[i]) prot[i] = 1'b0;
    // A start pulse stands for the last write pulse of a program or erase command.
    always @(posedge start_op) busy = 1'b1;
    always @(negedge reset_n) begin
        rst_busy = busy;
        busy = 1'b0;
    end
    always @(posedge reset_n) if (rst_busy) #2000 rst_busy = 1'b0;
    assign rb_low = busy || rst_busy;
    always @(negedge we_n) t_fall = $realtime;
    // Short strobes are ignored, so a glitch never changes protection.
    always @(posedge we_n) begin
        if (!ce_n && id_hv && oe_hv && !addr[0] && addr[1] && $realtime - t_fall > 5.0) begin
            if (addr[6]) foreach (prot[i]) prot[i] = 1'b0;
            else prot[addr[19:13]] = 1'b1;
        end
    end
    assign dev_oe = reset_n && !ce_n && !oe_n && we_n;
    assign rd = (id_hv && !addr[0] && addr[1]) ? {7'h00, prot[addr[19:13]]} : 8'h3c;
    // A released bus shows the inverse of the last byte rather than holding it.
    always @(negedge dev_oe) last = rd;
    assign dq = dev_oe ? rd : (host_oe ? host_dq : ~last);
endmodule : fbrsp_flash_model
`default_nettype wire

// *** verif/fbrsp_host_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module fbrsp_host_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    logic [6:0] cmd_sector = 7'h00;
    logic temp_unprot = 1'b0;
    logic start_op = 1'b0;
    logic cmd_ready, done, refused, corrupt, result_prot, dev_ready, power_down;
    logic [7:0] result_data, f_dq_i, f_dq_o;
    logic [19:0] f_addr;
    logic f_dq_oe, f_ce_n, f_oe_n, f_we_n, f_reset_n, f_id_hv, f_oe_hv, f_reset_hv, rb_low;
    logic f_rb_n;
    logic d, r, c;
    int errors = 0;
    int n_compared = 0;
    assign f_rb_n = !rb_low;
    always #2.5 clk = ~clk;
    fbrsp_host #(.PROT_PULSE_CYC(20), .UNPROT_PULSE_CYC(30), .NUM_SECTORS(19)) uut (
        .CLK(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_SECTOR(cmd_sector),
        .CMD_READY(cmd_ready), .TEMP_UNPROT(temp_unprot), .DONE(done), .REFUSED(refused),
        .CORRUPT(corrupt), .RESULT_PROT(result_prot), .RESULT_DATA(result_data),
        .DEV_READY(dev_ready), .POWER_DOWN(power_down), .F_ADDR(f_addr), .F_DQ_I(f_dq_i),
        .F_DQ_O(f_dq_o), .F_DQ_OE(f_dq_oe), .F_CE_N(f_ce_n), .F_OE_N(f_oe_n), .F_WE_N(f_we_n),
        .F_RESET_N(f_reset_n), .F_READY_BUSY_N(f_rb_n), .F_ID_HV(f_id_hv), .F_OE_HV(f_oe_hv),
        .F_RESET_HV(f_reset_hv));
    fbrsp_flash_model dev (.addr(f_addr), .ce_n(f_ce_n), .oe_n(f_oe_n), .we_n(f_we_n),
        .reset_n(f_reset_n), .id_hv(f_id_hv), .oe_hv(f_oe_hv), .host_dq(f_dq_o),
        .host_oe(f_dq_oe), .dq(f_dq_i), .rb_low(rb_low), .start_op(start_op));
    task automatic chk1(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %b, seen %b", name, exp, got);
        end
    endtask : chk1
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk8
    // Holds the request until taken, then gathers the one-cycle result pulses.
    task automatic run(input logic [2:0] op, input logic [6:0] sec);
        int i;
        @(posedge clk) #1;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_sector = sec;
        for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge clk);
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        d = 1'b0;
        r = 1'b0;
        c = 1'b0;
        for (i = 0; i < 6000 && !d && !r; i++) begin
            @(negedge clk);
            d = (done === 1'b1);
            r = (refused === 1'b1);
            c = c | (corrupt === 1'b1);
        end
        chk1("answer", 1'b1, d || r);
        @(negedge clk);
    endtask : run
    task automatic wrap_up;
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 50 && dev_ready !== 1'b1; i++) @(negedge clk);
        chk1("dev_ready", 1'b1, dev_ready);
        chk1("f_reset_hv", 1'b0, f_reset_hv);
        run(3'h4, 7'h03); chk8("verify", 8'h00, result_data);
        run(3'h2, 7'h03); chk1("done", 1'b1, d);
        run(3'h4, 7'h03); chk8("verify", 8'h01, result_data);
        chk1("result_prot", 1'b1, result_prot);
        run(3'h3, 7'h00); chk1("refused", 1'b1, r);
        for (int s = 0; s < 19; s++) run(3'h2, s[6:0]);
        run(3'h5, 7'h07); chk8("uverify", 8'h01, result_data);
        run(3'h3, 7'h00); chk1("done", 1'b1, d);
        run(3'h5, 7'h03); chk8("uverify", 8'h00, result_data);
        chk1("result_prot", 1'b0, result_prot);
        @(posedge clk) #1 start_op = 1'b1;
        repeat (10) @(posedge clk);
        #1 start_op = 1'b0;
        chk1("dev_ready", 1'b0, dev_ready);
        run(3'h2, 7'h01); chk1("refused", 1'b1, r);
        run(3'h0, 7'h00); chk1("corrupt", 1'b1, c);
        chk1("dev_ready", 1'b1, dev_ready);
        run(3'h0, 7'h00); chk1("corrupt", 1'b0, c);
        chk1("done", 1'b1, d);
        run(3'h1, 7'h00); chk1("power_down", 1'b1, power_down);
        chk1("f_reset_n", 1'b0, f_reset_n);
        run(3'h2, 7'h01); chk1("refused", 1'b1, r);
        run(3'h0, 7'h00); chk1("power_down", 1'b0, power_down);
        @(posedge clk) #1 temp_unprot = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk1("f_reset_hv", 1'b1, f_reset_hv);
        temp_unprot = 1'b0;
        wrap_up();
    end
    initial begin
        #300us;
        errors++;
        wrap_up();
    end
endmodule : fbrsp_host_tb
`default_nettype wire
